// [logic/eiu_pkg.sv]
package eiu_pkg;

  // Sizes
  localparam int unsigned NUM_EXT  = 4;
  localparam int unsigned NUM_GRP  = 4;
  localparam int unsigned GRP_W    = 8;
  localparam int unsigned NUM_PC   = NUM_GRP * GRP_W;
  localparam int unsigned SENSE_W  = 2;
  localparam int unsigned NUM_SRC  = NUM_EXT + NUM_GRP;
  localparam int unsigned VEC_W    = 3;

  // Data-space offsets
  localparam logic [7:0] OFS_PC_FLAGS  = 8'h3b;
  localparam logic [7:0] OFS_EXT_FLAGS = 8'h3c;
  localparam logic [7:0] OFS_EXT_EN    = 8'h3d;
  localparam logic [7:0] OFS_GRP_EN    = 8'h68;
  localparam logic [7:0] OFS_SENSE     = 8'h69;
  localparam logic [7:0] OFS_PC_MASK0  = 8'h6a;

  // I/O instruction window
  localparam logic [7:0] IO_OFS_DELTA  = 8'h20;
  localparam logic [7:0] IO_MAX        = 8'h3f;
  localparam logic [7:0] ADDR_NONE     = 8'hff;

  // Reset value and implemented bits
  localparam logic [7:0]  REG_RST      = 8'h00;
  localparam logic [31:0] PC_MASK_IMPL = 32'h07ff_ffff;

  // Vector numbers
  localparam logic [VEC_W-1:0] VEC_EXT0 = 3'h0;
  localparam logic [VEC_W-1:0] VEC_PC0  = 3'h4;

  typedef enum logic [1:0] {
    SENSE_LOW  = 2'b00,
    SENSE_ANY  = 2'b01,
    SENSE_FALL = 2'b10,
    SENSE_RISE = 2'b11
  } eiu_sense_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       io;
    logic [7:0] addr;
    logic [7:0] wdata;
  } eiu_reg_req_t;

  typedef struct packed {
    logic             valid;
    logic [VEC_W-1:0] id;
  } eiu_vec_ack_t;

endpackage : eiu_pkg

// [logic/eiu_pin_sampler.sv]
`timescale 1ns/100ps
module eiu_pin_sampler #(
  parameter int unsigned W = 4
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  // Pins
  input  wire logic [W-1:0] pin_i,
  // Sampled level and edges
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);

  logic [W-1:0] meta;
  logic [W-1:0] samp;
  logic [W-1:0] prev;

  // Two-stage synchroniser, then one sample history
  // No reset: history follows the pins through reset, so no false edge at release
  always_ff @(posedge clk_i) begin
    meta <= pin_i;
    samp <= meta;
    prev <= samp;
  end

  // Edges come from sampled values only
  assign level_o = samp;
  assign rise_o  = samp & ~prev;
  assign fall_o  = ~samp & prev;

  sequence s_pin_rise;
    !pin_i[0] ##1 pin_i[0] ##1 pin_i[0];
  endsequence

  property p_sync_rise;
    @(posedge clk_i) disable iff (sys_rst_i)
    s_pin_rise |=> rise_o[0];
  endproperty
  a_sync_rise: assert property (p_sync_rise) else $error("held rise not seen");

  property p_edge_source;
    @(posedge clk_i) disable iff (sys_rst_i)
    rise_o[0] |-> $past(pin_i[0], 2) && !$past(pin_i[0], 3);
  endproperty
  a_edge_source: assert property (p_edge_source) else $error("edge not from sampled pin");

endmodule : eiu_pin_sampler

// [logic/eiu_core.sv]
`timescale 1ns/100ps
// How it works
// - Two-bit sense: 00 low level, 01 any change, 10 falling, 11 rising.
// - Sense fields at bits 7:6, 5:4, 3:2, 1:0 for lines 3..0.
// - Edges and changes come from clocked samples, never the raw pin.
// - Edge or change pulses longer than one clock always make a request.
// - Line request needs its enable bit and the global interrupt flag.
// - Pin activity counts even when the pin is driven as output.
// - Every external line has its own vector.
// - A selected edge or change sets that line's flag.
// - Core vector acknowledge clears that line's flag.
// - Writing 1 clears a flag; writing 0 leaves it.
// - In low-level mode the flag reads zero; request follows live level.
// - Group 3 enable plus global flag: enabled change on 26:24 interrupts.
// - Group 2 enable plus global flag: enabled change on 23:16 interrupts.
// - Each group's mask register enables its pins one by one; group 3 has mask bits for 26:24 only.
// - Each pin-change group requests through its own vector.
// - External enable and both flag registers also decode at offset minus 0x20 for I/O.
// - Groups 1 and 0 work alike; group 0 covers inputs 7:0.
// - Enabled change sets group flag at 0x3B; vector or write 1 clears.
// - A cleared mask bit keeps its pin out of the group request.
// - Pin-change and low-level activity raise a wake request.
module eiu_core
  import eiu_pkg::*;
(
  // Clock and reset
  input  wire logic                           clk_i,
  input  wire logic                           sys_rst_i,
  // Pins
  input  wire logic [eiu_pkg::NUM_EXT-1:0]    ext_line_i,
  input  wire logic [eiu_pkg::NUM_PC-1:0]     pin_change_input_i,
  // Core side
  input  wire logic                           global_int_en_i,
  input  wire eiu_pkg::eiu_reg_req_t          reg_req_i,
  input  wire eiu_pkg::eiu_vec_ack_t          vec_ack_i,
  output logic [7:0]                          reg_rdata_o,
  output logic [eiu_pkg::NUM_SRC-1:0]         irq_req_o,
  output logic                                irq_valid_o,
  output logic [eiu_pkg::VEC_W-1:0]           irq_vector_o,
  output logic                                wake_o
);

  import eiu_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic logic [7:0] eff_addr(input logic io, input logic [7:0] a);
    if (!io) begin
      return a;
    end
    if (a > IO_MAX) begin
      return ADDR_NONE;
    end
    return a + IO_OFS_DELTA;
  endfunction : eff_addr

  logic [7:0] ofs;
  logic       wr;
  assign ofs = eff_addr(reg_req_i.io, reg_req_i.addr);
  assign wr  = reg_req_i.wr;

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling

  logic [NUM_EXT-1:0] ext_lvl;
  logic [NUM_EXT-1:0] ext_rise;
  logic [NUM_EXT-1:0] ext_fall;
  logic [NUM_PC-1:0]  pc_rise;
  logic [NUM_PC-1:0]  pc_fall;

  // No direction input: driven pins are sampled like any other
  eiu_pin_sampler #(.W(NUM_EXT)) u_ext (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (ext_line_i),
    .level_o   (ext_lvl),
    .rise_o    (ext_rise),
    .fall_o    (ext_fall)
  );

  eiu_pin_sampler #(.W(NUM_PC)) u_pc (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (pin_change_input_i),
    .level_o   (),
    .rise_o    (pc_rise),
    .fall_o    (pc_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic [NUM_EXT-1:0]         ext_en;
  logic [NUM_GRP-1:0]         grp_en;
  logic [7:0]                 sense;
  logic [GRP_W-1:0]           pc_mask [NUM_GRP];

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ext_en <= REG_RST[NUM_EXT-1:0];
      grp_en <= REG_RST[NUM_GRP-1:0];
      sense  <= REG_RST;
    end else if (wr) begin
      if (ofs == OFS_EXT_EN) ext_en <= reg_req_i.wdata[NUM_EXT-1:0];
      if (ofs == OFS_GRP_EN) grp_en <= reg_req_i.wdata[NUM_GRP-1:0];
      if (ofs == OFS_SENSE)  sense  <= reg_req_i.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    for (int g = 0; g < NUM_GRP; g++) begin
      if (sys_rst_i) begin
        pc_mask[g] <= REG_RST;
      end else if (wr && ofs == OFS_PC_MASK0 + 8'(g)) begin
        pc_mask[g] <= reg_req_i.wdata & PC_MASK_IMPL[g*GRP_W +: GRP_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger detection

  logic [NUM_EXT-1:0] ext_level_mode;
  logic [NUM_EXT-1:0] ext_set;
  logic [NUM_GRP-1:0] pc_set;

  always_comb begin
    for (int i = 0; i < NUM_EXT; i++) begin
      ext_level_mode[i] = 1'b0;
      unique case (eiu_sense_t'(sense[i*SENSE_W +: SENSE_W]))
        SENSE_LOW:  begin
          ext_set[i]        = 1'b0;
          ext_level_mode[i] = 1'b1;
        end
        SENSE_ANY:  ext_set[i] = ext_rise[i] | ext_fall[i];
        SENSE_FALL: ext_set[i] = ext_fall[i];
        SENSE_RISE: ext_set[i] = ext_rise[i];
      endcase
    end
    for (int g = 0; g < NUM_GRP; g++) begin
      pc_set[g] = |((pc_rise[g*GRP_W +: GRP_W] | pc_fall[g*GRP_W +: GRP_W]) & pc_mask[g]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags

  logic [NUM_EXT-1:0] ext_flag;
  logic [NUM_GRP-1:0] pc_flag;
  logic [NUM_EXT-1:0] ext_clr;
  logic [NUM_GRP-1:0] pc_clr;

  always_comb begin
    ext_clr = '0;
    pc_clr  = '0;
    if (wr && ofs == OFS_EXT_FLAGS) ext_clr = reg_req_i.wdata[NUM_EXT-1:0];
    if (wr && ofs == OFS_PC_FLAGS)  pc_clr  = reg_req_i.wdata[NUM_GRP-1:0];
    for (int i = 0; i < NUM_EXT; i++) begin
      if (vec_ack_i.valid && vec_ack_i.id == VEC_EXT0 + VEC_W'(i)) ext_clr[i] = 1'b1;
    end
    for (int g = 0; g < NUM_GRP; g++) begin
      if (vec_ack_i.valid && vec_ack_i.id == VEC_PC0 + VEC_W'(g)) pc_clr[g] = 1'b1;
    end
  end

  // A set in the clearing cycle wins
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ext_flag <= REG_RST[NUM_EXT-1:0];
      pc_flag  <= REG_RST[NUM_GRP-1:0];
    end else begin
      ext_flag <= ((ext_flag & ~ext_clr) | ext_set) & ~ext_level_mode;
      pc_flag  <= (pc_flag & ~pc_clr) | pc_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Requests and vectors

  logic [NUM_SRC-1:0] raw_req;
  logic [NUM_SRC-1:0] next_req;
  logic [VEC_W-1:0]   next_vector;

  always_comb begin
    for (int i = 0; i < NUM_EXT; i++) begin
      raw_req[i] = ext_en[i] & (ext_level_mode[i] ? ~ext_lvl[i] : ext_flag[i]);
    end
    for (int g = 0; g < NUM_GRP; g++) begin
      raw_req[NUM_EXT + g] = grp_en[g] & pc_flag[g];
    end
    next_req    = raw_req & {NUM_SRC{global_int_en_i}};
    next_vector = '0;
    for (int s = NUM_SRC - 1; s >= 0; s--) begin
      if (next_req[s]) next_vector = VEC_W'(s);
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_req_o    <= '0;
      irq_valid_o  <= 1'b0;
      irq_vector_o <= '0;
    end else begin
      irq_req_o    <= next_req;
      irq_valid_o  <= |next_req;
      irq_vector_o <= next_vector;
    end
  end

  // Wake request ignores the global flag
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= |raw_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = REG_RST;
    case (ofs)
      OFS_EXT_EN:    next_rdata[NUM_EXT-1:0] = ext_en;
      OFS_EXT_FLAGS: next_rdata[NUM_EXT-1:0] = ext_flag;
      OFS_PC_FLAGS:  next_rdata[NUM_GRP-1:0] = pc_flag;
      OFS_GRP_EN:    next_rdata[NUM_GRP-1:0] = grp_en;
      OFS_SENSE:     next_rdata = sense;
      default:       next_rdata = REG_RST;
    endcase
    for (int g = 0; g < NUM_GRP; g++) begin
      if (ofs == OFS_PC_MASK0 + 8'(g)) next_rdata = pc_mask[g];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= REG_RST;
    end else if (reg_req_i.rd) begin
      reg_rdata_o <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_rise_sets;
    @(posedge clk_i) disable iff (sys_rst_i)
    (sense[1:0] == SENSE_RISE) && ext_rise[0] |=> ext_flag[0];
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rising edge lost");

  property p_fall_sets;
    @(posedge clk_i) disable iff (sys_rst_i)
    (sense[3:2] == SENSE_FALL) && ext_fall[1] && !ext_rise[1] |=> ext_flag[1];
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("falling edge lost");

  property p_level_flag_zero;
    @(posedge clk_i) disable iff (sys_rst_i)
    (sense[5:4] == SENSE_LOW) |=> !ext_flag[2];
  endproperty
  a_level_flag_zero: assert property (p_level_flag_zero) else $error("level flag set");

  property p_w1c;
    @(posedge clk_i) disable iff (sys_rst_i)
    wr && ofs == OFS_EXT_FLAGS && reg_req_i.wdata[3] && !ext_set[3] |=> !ext_flag[3];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one kept flag");

  property p_ack_clears;
    @(posedge clk_i) disable iff (sys_rst_i)
    vec_ack_i.valid && vec_ack_i.id == VEC_EXT0 && !ext_set[0] |=> !ext_flag[0];
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("ack kept flag");

  property p_req_gated;
    @(posedge clk_i) disable iff (sys_rst_i)
    irq_req_o[0] |-> $past(ext_en[0]) && $past(global_int_en_i);
  endproperty
  a_req_gated: assert property (p_req_gated) else $error("ungated request");

  property p_pc_change;
    @(posedge clk_i) disable iff (sys_rst_i)
    (pc_rise[24] || pc_fall[24]) && pc_mask[3][0] |=> pc_flag[3];
  endproperty
  a_pc_change: assert property (p_pc_change) else $error("pin change lost");

  sequence s_io_en_write;
    wr && reg_req_i.io && reg_req_i.addr == OFS_EXT_EN - IO_OFS_DELTA;
  endsequence

  property p_io_alias;
    @(posedge clk_i) disable iff (sys_rst_i)
    s_io_en_write |=> ext_en == $past(reg_req_i.wdata[3:0]);
  endproperty
  a_io_alias: assert property (p_io_alias) else $error("I/O alias write lost");

  property p_vector;
    @(posedge clk_i) disable iff (sys_rst_i)
    irq_valid_o |-> irq_req_o[irq_vector_o];
  endproperty
  a_vector: assert property (p_vector) else $error("vector without request");

endmodule : eiu_core

// [bench/eiu_core_model.sv]
`timescale 1ns/100ps
module eiu_core_model (
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      sys_rst_i,
  // Bench control
  input  wire logic                      gie_i,
  input  wire logic                      ack_on_i,
  input  wire logic [3:0]                ack_wait_i,
  // Block side
  input  wire logic                      irq_valid_i,
  input  wire logic [eiu_pkg::VEC_W-1:0] irq_vector_i,
  output logic                           global_int_en_o,
  output eiu_pkg::eiu_vec_ack_t          vec_ack_o,
  // Observation
  output logic [eiu_pkg::VEC_W-1:0]      last_vec_o,
  output logic [7:0]                     ack_cnt_o
);
  import eiu_pkg::*;

  logic [3:0] wait_cnt;
  logic [1:0] hold_cnt;

  // Global interrupt flag
  assign global_int_en_o = gie_i;

  ////////////////////////////////////////////////////////////
  // Take the vector after a chosen delay, then let the request drop
  always_ff @(posedge clk_i) begin
    vec_ack_o <= '0;
    if (sys_rst_i) begin
      wait_cnt   <= '0;
      hold_cnt   <= '0;
      last_vec_o <= '0;
      ack_cnt_o  <= '0;
    end else if (hold_cnt != 2'd0) begin
      hold_cnt <= hold_cnt - 2'd1;
    end else if (irq_valid_i && ack_on_i) begin
      if (wait_cnt == ack_wait_i) begin
        vec_ack_o  <= {1'b1, irq_vector_i};
        last_vec_o <= irq_vector_i;
        ack_cnt_o  <= ack_cnt_o + 8'd1;
        wait_cnt   <= '0;
        hold_cnt   <= 2'd3;
      end else begin
        wait_cnt <= wait_cnt + 4'd1;
      end
    end else begin
      wait_cnt <= '0;
    end
  end

endmodule : eiu_core_model

// [bench/eiu_core_tb.sv]
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module eiu_core_tb;
  import eiu_pkg::*;

  logic         clk_i     = 1'b0;
  logic         sys_rst_i = 1'b1;
  logic [3:0]   ext       = 4'hf;
  logic [31:0]  pcin      = '0;
  eiu_reg_req_t req       = '0;
  logic         gie       = 1'b1;
  logic         ack_on    = 1'b0;
  logic [3:0]   ack_wait  = '0;
  logic [7:0]   rdata;
  logic [7:0]   irq;
  logic         valid;
  logic [2:0]   vec;
  logic         wake;
  logic         gie_w;
  eiu_vec_ack_t ack;
  logic [2:0]   last_vec;
  logic [7:0]   ack_cnt;
  int           err_count  = 0;
  int           num_checks = 0;
  int           seed       = 21695;

  always #2 clk_i = ~clk_i;

  eiu_core u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ext_line_i(ext), .pin_change_input_i(pcin),
    .global_int_en_i(gie_w), .reg_req_i(req), .vec_ack_i(ack), .reg_rdata_o(rdata), .irq_req_o(irq),
    .irq_valid_o(valid), .irq_vector_o(vec), .wake_o(wake));

  eiu_core_model u_core (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .gie_i(gie), .ack_on_i(ack_on),
    .ack_wait_i(ack_wait), .irq_valid_i(valid), .irq_vector_i(vec), .global_int_en_o(gie_w),
    .vec_ack_o(ack), .last_vec_o(last_vec), .ack_cnt_o(ack_cnt));

  ////////////////////////////////////////////////////////////
  // Expected flag for an edge-sense mode
  function automatic logic edge_hit(input logic [1:0] m, input logic fell);
    return (m == SENSE_ANY) || (fell ? (m == SENSE_FALL) : (m == SENSE_RISE));
  endfunction : edge_hit

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  task automatic reg_op(input logic w, input logic io, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req <= {w, ~w, io, a, d};
    @(posedge clk_i);
    req <= '0;
  endtask : reg_op

  task automatic rd_chk(input logic io, input logic [7:0] a, input logic [7:0] e);
    reg_op(1'b0, io, a, 8'h00);
    #1;
    `CHK(rdata, e)
  endtask : rd_chk

  task automatic wait_req(input logic [7:0] e);
    for (int i = 0; i < 12 && irq !== e; i++) begin
      @(posedge clk_i);
      #1;
    end
    `CHK(irq, e)
  endtask : wait_req

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////
  initial begin
    int n, m, g, b;
    logic [7:0] v;
    cyc(16);
    sys_rst_i <= 1'b0;
    rd_chk(0, OFS_EXT_FLAGS, REG_RST);
    rd_chk(0, OFS_EXT_EN, REG_RST);
    rd_chk(0, OFS_GRP_EN, REG_RST);
    rd_chk(0, OFS_SENSE, REG_RST);
    rd_chk(0, 8'h50, 8'h00);
    v = 8'($random(seed));
    reg_op(1, 0, OFS_SENSE, v);
    rd_chk(0, OFS_SENSE, v);
    reg_op(1, 1, OFS_EXT_EN - IO_OFS_DELTA, 8'h0a);
    rd_chk(0, OFS_EXT_EN, 8'h0a);
    // Every line in every sense mode
    for (n = 0; n < 4; n++) begin
      for (m = 0; m < 4; m++) begin
        reg_op(1, 0, OFS_SENSE, 8'(m << (2 * n)));
        reg_op(1, 0, OFS_EXT_EN, 8'(1 << n));
        reg_op(1, 1, OFS_EXT_FLAGS - IO_OFS_DELTA, 8'h0f);
        @(posedge clk_i);
        ext[n] <= 1'b0;
        if (m == 0) begin
          wait_req(8'(1 << n));
          `CHK(vec, 3'(n))
          `CHK(valid, 1'b1)
          rd_chk(0, OFS_EXT_FLAGS, 8'h00);
          @(posedge clk_i);
          gie <= 1'b0;
          cyc(3);
          #1;
          `CHK({irq, valid, wake}, 10'h001)
          @(posedge clk_i);
          gie <= 1'b1;
        end else begin
          cyc(8);
          rd_chk(0, OFS_EXT_FLAGS, 8'(edge_hit(2'(m), 1'b1)) << n);
          reg_op(1, 0, OFS_EXT_FLAGS, 8'h00);
          rd_chk(0, OFS_EXT_FLAGS, 8'(edge_hit(2'(m), 1'b1)) << n);
          reg_op(1, 0, OFS_EXT_FLAGS, 8'(1 << n));
        end
        @(posedge clk_i);
        ext[n] <= 1'b1;
        cyc(8);
        wait_req((m == 0) ? 8'h00 : 8'(edge_hit(2'(m), 1'b0)) << n);
        reg_op(1, 0, OFS_EXT_EN, 8'h00);
        wait_req(8'h00);
      end
    end
    // Core takes the vector after a random delay
    reg_op(1, 0, OFS_SENSE, 8'h30);
    reg_op(1, 0, OFS_EXT_EN, 8'h04);
    @(posedge clk_i);
    ack_on   <= 1'b1;
    ack_wait <= 4'($unsigned($random(seed)) % 8);
    ext[2]   <= 1'b0;
    cyc(3);
    ext[2] <= 1'b1;
    for (n = 0; n < 40 && ack_cnt === 8'h00; n++) begin
      @(posedge clk_i);
      #1;
    end
    `CHK(ack_cnt, 8'h01)
    `CHK(last_vec, VEC_EXT0 + 3'd2)
    wait_req(8'h00);
    rd_chk(0, OFS_EXT_FLAGS, 8'h00);
    @(posedge clk_i);
    ack_on <= 1'b0;
    // Pin-change groups with one masked-in pin each
    for (g = 0; g < 4; g++) begin
      b = (g == 3) ? $unsigned($random(seed)) % 3 : $unsigned($random(seed)) % 8;
      reg_op(1, 0, OFS_PC_MASK0 + 8'(g), 8'(1 << b));
      reg_op(1, 0, OFS_GRP_EN, 8'(1 << g));
      @(posedge clk_i);
      pcin[g * 8 + (b + 1) % 8] <= ~pcin[g * 8 + (b + 1) % 8];
      cyc(8);
      rd_chk(0, OFS_PC_FLAGS, 8'h00);
      @(posedge clk_i);
      pcin[g * 8 + b] <= ~pcin[g * 8 + b];
      wait_req(8'(8'h10 << g));
      `CHK(vec, VEC_PC0 + 3'(g))
      rd_chk(1, OFS_PC_FLAGS - IO_OFS_DELTA, 8'(1 << g));
      reg_op(1, 0, OFS_PC_FLAGS, 8'(1 << g));
      wait_req(8'h00);
    end
    // Core takes a group vector, which clears that group's flag
    reg_op(1, 0, OFS_GRP_EN, 8'h01);
    @(posedge clk_i);
    ack_on    <= 1'b1;
    pcin[7:0] <= ~pcin[7:0];
    for (n = 0; n < 40 && ack_cnt === 8'h01; n++) begin
      @(posedge clk_i);
      #1;
    end
    `CHK(ack_cnt, 8'h02)
    `CHK(last_vec, VEC_PC0)
    wait_req(8'h00);
    rd_chk(0, OFS_PC_FLAGS, 8'h00);
    test_done();
  end

  // Hang guard
  initial begin
    cyc(60000);
    err_count++;
    test_done();
  end

endmodule : eiu_core_tb
